// *** hdl/pase_map.svh ***
`ifndef PASE_MAP_SVH
`define PASE_MAP_SVH
// clock and the derived seconds tick
`define PASE_CLK_PERIOD_NS 10
`define PASE_SEC_NS        1000000000
`define PASE_SEC_CYCLES    (`PASE_SEC_NS / `PASE_CLK_PERIOD_NS)
// operator time-outs, figures in their own unit, then in seconds
`define PASE_DISP_TMO_MIN  3
`define PASE_DISP_TMO_S    (`PASE_DISP_TMO_MIN * 60)
`define PASE_EDIT_PWR_S    30
`define PASE_EDIT_GEN_S    60
`define PASE_BLOCK_S       5
`define PASE_RF_PAUSE_S    2
// apb register offsets (byte addresses)
`define PASE_A_STATUS      8'h00
`define PASE_A_TIMEOUT     8'h04
`define PASE_A_POWER       8'h08
`define PASE_A_SENS        8'h0C
`define PASE_A_TXMODE      8'h10
`define PASE_A_PROT        8'h14
`define PASE_A_PDOWN       8'h18
// menu screen codes on the screen input
`define PASE_SCR_PASSWORD  4'h0
`define PASE_SCR_PW_MGMT   4'h1
`define PASE_SCR_SW_RESET  4'h2
`define PASE_SCR_POWER     4'h3
`define PASE_SCR_BB_SENS   4'h4
`define PASE_SCR_AUX_SENS  4'h5
`define PASE_SCR_MODE      4'h6
`define PASE_SCR_REFL      4'h7
`define PASE_SCR_LIMITER   4'h8
`define PASE_SCR_FSTEP     4'h9
`define PASE_SCR_PDOWN     4'hA
// needed level per screen, two bits per screen code, screen 0 lowest
`define PASE_REQ_TABLE     32'h002FEA94
// value limits and steps
`define PASE_POWER_MAX     12'h0FA
`define PASE_SENS_MAX      12'h020
`define PASE_REFL_MAX      12'h032
`define PASE_THR_MAX       12'h01F
`define PASE_PCT_MAX       12'h064
`define PASE_TIME_MAX      12'h0FF
`define PASE_FREQ_MAX      12'h802
`define PASE_FREQ_COARSE   12'h00A
`define PASE_PCT_FULL      15'h0064
// setting reset values
`define PASE_RST_POWER     8'hFA
`define PASE_RST_BB        6'h07
`define PASE_RST_AUX       6'h18
`define PASE_RST_PRE       2'h2
`define PASE_RST_FREQ      12'h000
`define PASE_RST_REFL      8'h1E
`define PASE_RST_THR       5'h10
`define PASE_RST_PCT       7'h32
`define PASE_RST_PTIME     8'h3C
`endif

// *** hdl/pase_pkg.sv ***
package pase_pkg;
  typedef enum logic [2:0] {
    st_idle, st_edit, st_pw_new, st_pw_conf,
    st_err_block, st_err_wait, st_locked, st_lockout
  } pase_state_t;
  typedef enum logic [1:0] {
    right_only_mono_mode, stereo_mode,
    summed_mono_mode, external_composite_mode
  } pase_txmode_t;
  typedef struct packed {
    logic [7:0]   power;
    logic [5:0]   bb;
    logic [5:0]   aux;
    pase_txmode_t mode;
    logic [1:0]   pre;
    logic         fstep;
    logic [11:0]  freq;
    logic [7:0]   refl;
    logic         lim_on;
    logic [4:0]   thr;
    logic         pd_en;
    logic [6:0]   pct;
    logic [7:0]   ptime;
  } pase_set_t;
  typedef struct packed {
    pase_state_t     st;
    logic [1:0]      level;
    logic            locked;
    logic            pw1_on;
    logic            pw2_on;
    logic [2:0][15:0] code;
    logic [15:0]     new_code;
    logic [1:0]      tgt;
    logic            flip;
    logic [3:0]      scr;
    logic [1:0]      fld;
    pase_set_t       cur;
    pase_set_t       wrk;
    logic [7:0]      pd_sec;
    logic [7:0]      applied;
    logic [15:0]     tmo;
    logic [31:0]     rdata;
    logic            err;
    logic            inval;
    logic            denied;
    logic            swrst;
    logic            store;
  } pase_panel_st_t;
endpackage

// *** hdl/pase_tick.sv ***
`timescale 1ns/1ns
module pase_tick #(
  parameter int unsigned CYCLES = 100
) (
  input  wire logic clk,
  input  wire logic reset,
  output wire logic tick
);
  import pase_pkg::*;
  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } pase_tick_st_t;
  pase_tick_st_t q;
  pase_tick_st_t n;
  if (CYCLES < 2) begin : g_chk
    $error("pase_tick: CYCLES must be at least 2");
  end
  // wrap at CYCLES-1 so the tick period is exactly CYCLES clocks
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (q.cnt == CW'(CYCLES - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = CW'(q.cnt + 1'b1);
    end
  end
  always_ff @(posedge clk) begin
    if (reset) q <= '0;
    else q <= n;
  end
  assign tick = q.tick;
endmodule

// *** hdl/pase_timer.sv ***
`timescale 1ns/1ns
module pase_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         clear,
  input  wire logic [W-1:0] value,
  output wire logic         busy,
  output wire logic         expired
);
  import pase_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         expired;
  } pase_timer_st_t;
  pase_timer_st_t q;
  pase_timer_st_t n;
  if (W < 2) begin : g_chk
    $error("pase_timer: W must be at least 2");
  end
  // seconds down-counter; a load of zero leaves it idle
  always_comb begin
    n = q;
    n.expired = 1'b0;
    if (clear) begin
      n.busy = 1'b0;
    end else if (load) begin
      n.cnt = value;
      n.busy = (value != '0);
    end else if (q.busy && tick) begin
      n.cnt = W'(q.cnt - 1'b1);
      if (q.cnt == W'(1)) begin
        n.busy = 1'b0;
        n.expired = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) q <= '0;
    else q <= n;
  end
  assign busy = q.busy;
  assign expired = q.expired;
endmodule

// *** hdl/pase_panel.sv ***
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "pase_map.svh"
// How it works
// - never show codes; refuse levels above granted
// - own-level status or code change needs current code
// - higher level sets lower code, with confirmation
// - level three drops at display time-out
// - any key outside lockout restarts the display time-out; a restart stops it instead, even on the enter that starts a soft reset
// - level-one on: time-out locks panel, asks code
// - bad code while locked: wait time-out
// - soft reset only at level one or above
// - resets keep settings; rf pauses briefly
// - power edit applied live before enter
// - enter stores setting, escape discards it
// - power edit abandoned after thirty idle seconds
// - baseband sensitivity minus 3.5 to 12.5 dBm
// - auxiliary sensitivity minus 12 to 4 dBm
// - confirm mismatch: error, block five seconds
// - four transmission modes, four pre-emphasis values
// - level three picks 100 or 10 kHz step
// - left/right pick field, up/down change value
// - reflected power limit programmable, default 3.0 W
// - limiter: left/right toggles, up/down threshold
// - power-down scales power after programmed time
// - unknown or aborted code: invalid, level kept
module pase_panel #(
  parameter int unsigned TICK_CYCLES = `PASE_SEC_CYCLES,
  parameter logic [15:0] CODE1       = 16'h1111, // arbitrary value
  parameter logic [15:0] CODE2       = 16'h2222, // arbitrary value
  parameter logic [15:0] CODE3       = 16'h3333, // arbitrary value
  parameter logic        PW1_ON      = 1'b0,
  parameter logic        PW2_ON      = 1'b1
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   mains_restart,
  input  wire logic                   key_up,
  input  wire logic                   key_down,
  input  wire logic                   key_left,
  input  wire logic                   key_right,
  input  wire logic                   key_enter,
  input  wire logic                   key_escape,
  input  wire logic [3:0]             screen,
  input  wire logic [15:0]            code_in,
  output wire logic [1:0]             auth_level,
  output wire logic                   panel_locked,
  output wire logic                   lockout,
  output wire logic                   pw_invalid,
  output wire logic                   access_denied,
  output wire logic                   pw_error,
  output wire logic                   input_blocked,
  output wire logic                   edit_active,
  output wire logic [1:0]             edit_field,
  output wire logic                   sw_reset_pulse,
  output wire logic                   store_strobe,
  output wire logic [3:0]             store_screen,
  output wire logic                   rf_mute,
  output wire logic [7:0]             power_applied,
  output wire logic [5:0]             bb_sens,
  output wire logic [5:0]             aux_sens,
  output pase_pkg::pase_txmode_t      tx_mode,
  output wire logic [1:0]             preemphasis,
  output wire logic                   freq_step_fine,
  output wire logic [11:0]            freq_code,
  output wire logic [7:0]             refl_limit,
  output wire logic                   limiter_on,
  output wire logic [4:0]             limiter_thr,
  output wire logic                   pdown_en,
  output wire logic [6:0]             pdown_pct,
  output wire logic [7:0]             pdown_time,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output wire logic [31:0]            prdata,
  output wire logic                   pready,
  output wire logic                   pslverr
);
  import pase_pkg::*;
  localparam logic [1:0] BASE_RST = PW1_ON ? 2'h0 : (PW2_ON ? 2'h1 : 2'h2);
  localparam pase_set_t SET_RST = '{
    power: `PASE_RST_POWER, bb: `PASE_RST_BB, aux: `PASE_RST_AUX,
    mode: stereo_mode, pre: `PASE_RST_PRE, fstep: 1'b0,
    freq: `PASE_RST_FREQ, refl: `PASE_RST_REFL, lim_on: 1'b0,
    thr: `PASE_RST_THR, pd_en: 1'b0, pct: `PASE_RST_PCT,
    ptime: `PASE_RST_PTIME};
  pase_panel_st_t    q;
  pase_panel_st_t    n;
  logic              tick;
  logic [3:0]        ld;
  logic [3:0]        clr;
  logic [3:0][15:0]  lv;
  logic [3:0]        busy;
  logic [3:0]        expd;
  logic              any;
  logic              mv;
  logic              restart;
  logic              ok;
  logic [1:0]        m;
  logic [1:0]        req;
  logic [7:0]        pbase;
  logic [14:0]       prod;
  logic [3:0]        escr;
  if (TICK_CYCLES < 2) begin : g_chk
    $error("pase_panel: TICK_CYCLES must be at least 2");
  end

  // highest level whose code matches, zero when none does
  function automatic logic [1:0] match(input logic [2:0][15:0] c,
                                       input logic [15:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v == c[2]) r = 2'h3;
    else if (v == c[1]) r = 2'h2;
    else if (v == c[0]) r = 2'h1;
    return r;
  endfunction

  // saturating step of an index; hi must not be below inc
  function automatic logic [11:0] bump(input logic [11:0] v,
                                       input logic [11:0] hi,
                                       input logic [11:0] inc,
                                       input logic up,
                                       input logic dn);
    logic [11:0] r;
    r = v;
    if (up) r = (v > 12'(hi - inc)) ? hi : 12'(v + inc);
    else if (dn) r = (v < inc) ? 12'h000 : 12'(v - inc);
    return r;
  endfunction

  pase_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  // timers: 0 display, 1 edit, 2 error block, 3 rf pause
  for (genvar i = 0; i < 4; i++) begin : g_tmr
    pase_timer #(
      .W (16)
    ) u_tmr (
      .clk     (clk),
      .reset   (reset),
      .tick    (tick),
      .load    (ld[i]),
      .clear   (clr[i]),
      .value   (lv[i]),
      .busy    (busy[i]),
      .expired (expd[i])
    );
  end

  // whole control path; later blocks override earlier ones on purpose
  always_comb begin
    n = q;
    ld = 4'h0;
    clr = 4'h0;
    ok = 1'b0;
    m = match(q.code, code_in);
    n.inval = 1'b0;
    n.denied = 1'b0;
    n.swrst = 1'b0;
    n.store = 1'b0;
    any = key_up | key_down | key_left | key_right | key_enter | key_escape;
    mv = key_up | key_down | key_left | key_right;
    restart = mains_restart;
    req = 2'(`PASE_REQ_TABLE >> {screen, 1'b0});
    escr = (q.st == st_edit) ? q.scr : screen;
    lv[0] = q.tmo;
    lv[1] = (escr == `PASE_SCR_POWER) ? 16'(`PASE_EDIT_PWR_S)
                                      : 16'(`PASE_EDIT_GEN_S);
    lv[2] = 16'(`PASE_BLOCK_S);
    lv[3] = 16'(`PASE_RF_PAUSE_S);
    // a lockout must not be stretched by key presses, or it never ends
    if (any && q.st != st_lockout) ld[0] = 1'b1;
    case (q.st)
      st_idle: begin
        if (key_enter && req > q.level) begin
          n.denied = 1'b1;
        end else if (key_enter) begin
          case (screen)
            `PASE_SCR_PASSWORD: begin
              if (m == 2'h0) n.inval = 1'b1;
              else n.level = m;
            end
            `PASE_SCR_PW_MGMT: begin
              n.st = st_pw_new;
              n.tgt = q.level;
              n.flip = 1'b0;
            end
            `PASE_SCR_SW_RESET: begin
              restart = 1'b1;
              n.swrst = 1'b1;
            end
            default: begin
              if (screen >= `PASE_SCR_POWER && screen <= `PASE_SCR_PDOWN)
              begin
                n.st = st_edit;
                n.scr = screen;
                n.fld = 2'h0;
                n.wrk = q.cur;
                ld[1] = 1'b1;
              end
            end
          endcase
        end else if (key_escape && screen == `PASE_SCR_PASSWORD) begin
          n.inval = 1'b1;
        end
      end
      st_edit: begin
        if (key_escape || expd[1]) begin
          n.wrk = q.cur;
          n.st = st_idle;
          clr[1] = 1'b1;
        end else if (key_enter) begin
          n.cur = q.wrk;
          n.store = 1'b1;
          n.st = st_idle;
          clr[1] = 1'b1;
        end else if (mv) begin
          ld[1] = 1'b1;
          if (key_right) n.fld = (q.fld == 2'h2) ? 2'h0 : 2'(q.fld + 2'h1);
          if (key_left) n.fld = (q.fld == 2'h0) ? 2'h2 : 2'(q.fld - 2'h1);
          case (q.scr)
            `PASE_SCR_POWER: n.wrk.power = 8'(bump({4'h0, q.wrk.power},
              `PASE_POWER_MAX, 12'h001, key_up, key_down));
            `PASE_SCR_BB_SENS: n.wrk.bb = 6'(bump({6'h00, q.wrk.bb},
              `PASE_SENS_MAX, 12'h001, key_up, key_down));
            `PASE_SCR_AUX_SENS: n.wrk.aux = 6'(bump({6'h00, q.wrk.aux},
              `PASE_SENS_MAX, 12'h001, key_up, key_down));
            `PASE_SCR_MODE: begin
              case (q.fld)
                2'h0: begin
                  if (key_up) n.wrk.mode = pase_txmode_t'(2'(q.wrk.mode + 2'h1));
                  if (key_down) n.wrk.mode = pase_txmode_t'(2'(q.wrk.mode - 2'h1));
                end
                2'h1: begin
                  if (key_up) n.wrk.pre = 2'(q.wrk.pre + 2'h1);
                  if (key_down) n.wrk.pre = 2'(q.wrk.pre - 2'h1);
                end
                default: n.wrk.freq = bump(q.wrk.freq, `PASE_FREQ_MAX,
                  q.cur.fstep ? 12'h001 : `PASE_FREQ_COARSE,
                  key_up, key_down);
              endcase
            end
            `PASE_SCR_REFL: n.wrk.refl = 8'(bump({4'h0, q.wrk.refl},
              `PASE_REFL_MAX, 12'h001, key_up, key_down));
            `PASE_SCR_LIMITER: begin
              if (key_left || key_right) n.wrk.lim_on = ~q.wrk.lim_on;
              n.wrk.thr = 5'(bump({7'h00, q.wrk.thr},
                `PASE_THR_MAX, 12'h001, key_up, key_down));
            end
            `PASE_SCR_FSTEP: begin
              if (key_up || key_down) n.wrk.fstep = ~q.wrk.fstep;
            end
            `PASE_SCR_PDOWN: begin
              case (q.fld)
                2'h0: if (key_up || key_down) n.wrk.pd_en = ~q.wrk.pd_en;
                2'h1: n.wrk.pct = 7'(bump({5'h00, q.wrk.pct},
                  `PASE_PCT_MAX, 12'h001, key_up, key_down));
                default: n.wrk.ptime = 8'(bump({4'h0, q.wrk.ptime},
                  `PASE_TIME_MAX, 12'h001, key_up, key_down));
              endcase
            end
            default: ;
          endcase
        end
      end
      st_pw_new: begin
        if (key_escape) begin
          n.st = st_idle;
        end else if (key_left && q.tgt > 2'h1) begin
          n.tgt = 2'(q.tgt - 2'h1);
          n.flip = 1'b0;
        end else if (key_right && q.tgt < q.level) begin
          n.tgt = 2'(q.tgt + 2'h1);
          n.flip = 1'b0;
        end else if (key_up || key_down) begin
          n.flip = ~q.flip;
        end else if (key_enter) begin
          n.new_code = code_in;
          n.st = st_pw_conf;
        end
      end
      st_pw_conf: begin
        // own level: old code; lower level: repeat of the new code
        ok = (q.tgt == q.level) ? (code_in == q.code[2'(q.tgt - 2'h1)])
                                : (code_in == q.new_code);
        if (key_escape) begin
          n.st = st_idle;
        end else if (key_enter && ok) begin
          n.code[2'(q.tgt - 2'h1)] = q.new_code;
          if (q.flip && q.tgt == 2'h1) n.pw1_on = ~q.pw1_on;
          if (q.flip && q.tgt == 2'h2) n.pw2_on = ~q.pw2_on;
          n.st = st_idle;
        end else if (key_enter) begin
          n.st = st_err_block;
          ld[2] = 1'b1;
        end
      end
      st_err_block: begin
        if (expd[2]) n.st = st_err_wait;
      end
      st_err_wait: begin
        if (key_escape) n.st = st_idle;
      end
      st_locked: begin
        if (key_enter && m != 2'h0) begin
          n.level = m;
          n.locked = 1'b0;
          n.st = st_idle;
        end else if (key_enter || key_escape) begin
          n.inval = 1'b1;
          n.st = st_lockout;
        end
      end
      st_lockout: ;
      default: n.st = st_idle;
    endcase
    // display time-out: revoke level three, lock if level one is on
    if (expd[0]) begin
      if (q.level == 2'h3) n.level = 2'h2;
      if (q.st == st_lockout) begin
        n.st = st_locked;
      end else if (q.pw1_on) begin
        n.locked = 1'b1;
        n.level = 2'h0;
        n.st = st_locked;
        n.wrk = q.cur;
        clr[1] = 1'b1;
      end
    end
    // restart re-enters like power-up but keeps every setting and code
    if (restart) begin
      n.st = q.pw1_on ? st_locked : st_idle;
      n.locked = q.pw1_on;
      n.level = q.pw1_on ? 2'h0 : (q.pw2_on ? 2'h1 : 2'h2);
      n.wrk = q.cur;
      clr[2:0] = 3'h7;
      ld[3] = 1'b1;
    end
    // live power: edited value first, then power-down scaling
    pbase = (q.st == st_edit && q.scr == `PASE_SCR_POWER)
            ? q.wrk.power : q.cur.power;
    if (!q.cur.pd_en) n.pd_sec = 8'h00;
    else if (tick && q.pd_sec < q.cur.ptime) n.pd_sec = 8'(q.pd_sec + 8'h01);
    prod = 15'(pbase) * 15'(q.cur.pct); // widen before the product
    n.applied = (q.cur.pd_en && q.pd_sec >= q.cur.ptime)
                ? 8'(prod / `PASE_PCT_FULL) : pbase;
    // apb: decode and fetch in setup, act in the zero-wait access
    if (psel && !penable) begin
      n.err = 1'b0;
      case (paddr)
        `PASE_A_STATUS: n.rdata = {23'h0, busy[3], q.pw2_on, q.pw1_on,
          q.st == st_err_block, q.st == st_edit, q.st == st_lockout,
          q.locked, q.level};
        `PASE_A_TIMEOUT: n.rdata = {16'h0000, q.tmo};
        `PASE_A_POWER: n.rdata = {16'h0000, q.applied, q.cur.power};
        `PASE_A_SENS: n.rdata = {18'h0, q.cur.aux, 2'h0, q.cur.bb};
        `PASE_A_TXMODE: n.rdata = {4'h0, q.cur.freq, 11'h0, q.cur.fstep,
          q.cur.pre, q.cur.mode};
        `PASE_A_PROT: n.rdata = {11'h0, q.cur.thr, 7'h0, q.cur.lim_on,
          q.cur.refl};
        `PASE_A_PDOWN: n.rdata = {8'h00, q.cur.ptime, 1'b0, q.cur.pct,
          7'h00, q.cur.pd_en};
        default: begin
          n.rdata = 32'h0000_0000;
          n.err = 1'b1;
        end
      endcase
      if (pwrite && paddr != `PASE_A_TIMEOUT) n.err = 1'b1;
    end
    if (psel && penable && pwrite && !q.err) n.tmo = pwdata[15:0];
  end

  // reset loads constants only; codes come from elaboration parameters
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.st <= PW1_ON ? st_locked : st_idle;
      q.level <= BASE_RST;
      q.locked <= PW1_ON;
      q.pw1_on <= PW1_ON;
      q.pw2_on <= PW2_ON;
      q.code <= {CODE3, CODE2, CODE1};
      q.cur <= SET_RST;
      q.wrk <= SET_RST;
      q.applied <= `PASE_RST_POWER;
      q.tmo <= 16'(`PASE_DISP_TMO_S);
    end else begin
      q <= n;
    end
  end

  // outputs straight from state
  assign auth_level = q.level;
  assign panel_locked = q.locked;
  assign lockout = (q.st == st_lockout);
  assign pw_invalid = q.inval;
  assign access_denied = q.denied;
  assign pw_error = (q.st == st_err_block) || (q.st == st_err_wait);
  assign input_blocked = (q.st == st_err_block) || (q.st == st_lockout);
  assign edit_active = (q.st == st_edit);
  assign edit_field = q.fld;
  assign sw_reset_pulse = q.swrst;
  assign store_strobe = q.store;
  assign store_screen = q.scr;
  assign rf_mute = busy[3];
  assign power_applied = q.applied;
  assign bb_sens = q.cur.bb;
  assign aux_sens = q.cur.aux;
  assign tx_mode = q.cur.mode;
  assign preemphasis = q.cur.pre;
  assign freq_step_fine = q.cur.fstep;
  assign freq_code = q.cur.freq;
  assign refl_limit = q.cur.refl;
  assign limiter_on = q.cur.lim_on;
  assign limiter_thr = q.cur.thr;
  assign pdown_en = q.cur.pd_en;
  assign pdown_pct = q.cur.pct;
  assign pdown_time = q.cur.ptime;
  // zero-wait slave; error only flags bad decode or write to read-only
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.err;
endmodule

// *** verification/pase_panel_properties.sv ***
`timescale 1ns/1ns
// port-level checks of the panel; one clock domain
module pase_panel_properties (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       key_enter,
  input wire logic       key_escape,
  input wire logic [3:0] screen,
  input wire logic [1:0] auth_level,
  input wire logic       pw_invalid,
  input wire logic       access_denied,
  input wire logic       pw_error,
  input wire logic       input_blocked,
  input wire logic       edit_active,
  input wire logic       sw_reset_pulse,
  input wire logic       store_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // refusals, stores and resets answer an enter one cycle earlier
  a_deny_cause: assert property (access_denied |-> $past(key_enter))
    else $error("refusal without enter");
  a_store_cause: assert property (store_strobe |-> $past(edit_active))
    else $error("store outside an edit");
  a_soft_reset: assert property (sw_reset_pulse |->
    $past(key_enter) && $past(screen) == 4'h2 && $past(auth_level) != 2'h0)
    else $error("soft reset without level");
  a_invalid_keep: assert property (pw_invalid |-> $stable(auth_level))
    else $error("level changed on bad code");
  a_edit_level: assert property ($rose(edit_active) &&
    $past(screen) == 4'h3 |-> auth_level >= 2'h2)
    else $error("power edit below level two");
  a_escape_drop: assert property (edit_active && key_escape &&
    !input_blocked |=> !edit_active && !store_strobe)
    else $error("escape kept the edit");
  // a 5 s block is far longer than eight cycles at any tick rate used
  a_block_hold: assert property ($rose(pw_error) |-> input_blocked[*8])
    else $error("error block too short");
  a_block_esc: assert property (pw_error && input_blocked &&
    key_escape |=> pw_error)
    else $error("escape honoured while blocked");
endmodule
bind pase_panel pase_panel_properties pase_panel_properties_inst (.*);

// *** verification/pase_operator.sv ***
`timescale 1ns/1ns
// operator at the panel: one clean key pulse per request, never two keys
module pase_operator (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] key,
  output logic      [5:0] keys
);
  // a pulse lasts one cycle, like a debounced press
  always_ff @(posedge clk) begin
    keys <= go ? 6'h01 << key : 6'h00;
  end
endmodule

// *** verification/tb_pase_panel.sv ***
`timescale 1ns/1ns
module tb_pase_panel;
  logic        clk = 0, reset = 1, mains_restart = 0, go = 0, slv;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        pw_error, input_blocked, edit_active, rf_mute;
  logic [2:0]  key = 0;
  logic [5:0]  keys;
  logic [3:0]  screen = 0;
  logic [15:0] code_in = 0;
  logic [7:0]  paddr = 0, power_applied, refl_limit;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0]  auth_level;
  int          err_count = 0, tests_run = 0;
  // ten-cycle seconds so the timers fit the run
  pase_panel #(.TICK_CYCLES(10)) pase_panel_inst (
    .clk, .reset, .mains_restart, .key_up(keys[0]), .key_down(keys[1]),
    .key_left(keys[2]), .key_right(keys[3]), .key_enter(keys[4]),
    .key_escape(keys[5]), .screen, .code_in, .auth_level,
    .panel_locked(), .lockout(), .pw_invalid(), .access_denied(),
    .pw_error, .input_blocked, .edit_active, .edit_field(),
    .sw_reset_pulse(), .store_strobe(), .store_screen(), .rf_mute,
    .power_applied, .bb_sens(), .aux_sens(), .tx_mode(), .preemphasis(),
    .freq_step_fine(), .freq_code(), .refl_limit, .limiter_on(),
    .limiter_thr(), .pdown_en(), .pdown_pct(), .pdown_time(), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  pase_operator pase_operator_inst (.clk, .go, .key, .keys);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t seen %h want %h", $time, s, e);
    end
  endtask
  // key k on screen s with code c; outputs settled on return
  task automatic press(input logic [2:0] k, input logic [3:0] s,
                       input logic [15:0] c);
    screen <= s;
    code_in <= c;
    key <= k;
    go <= 1;
    @(posedge clk) go <= 0;
    repeat (3) @(posedge clk);
  endtask
  // apb: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk(refl_limit, 8'h1E);
    apb(0, 8'h40, 0);
    chk(slv, 1);
    chk(rd, 0);
    press(4, 3, 0);
    chk({auth_level, edit_active}, {2'h1, 1'b0});
    press(4, 0, 16'h1234);
    chk(auth_level, 1);
    press(4, 0, 16'h2222);
    chk(auth_level, 2);
    $display("test access done");
    press(4, 3, 0);
    press(1, 3, 0);
    chk(power_applied, 8'hF9);
    press(5, 3, 0);
    chk(power_applied, 8'hFA);
    press(4, 3, 0);
    press(1, 3, 0);
    press(4, 3, 0);
    press(4, 3, 0);
    press(1, 3, 0);
    repeat (330) @(posedge clk);
    chk({edit_active, power_applied}, {1'b0, 8'hF9});
    $display("test power edit done");
    press(4, 1, 0);
    press(4, 1, 16'h5555);
    press(4, 1, 16'h0BAD);
    chk(input_blocked, 1);
    press(5, 1, 0);
    repeat (60) @(posedge clk);
    chk({pw_error, input_blocked}, {1'b1, 1'b0});
    press(5, 1, 0);
    chk(pw_error, 0);
    $display("test confirm done");
    apb(1, 8'h04, 3);
    press(4, 0, 16'h3333);
    chk(auth_level, 3);
    apb(0, 8'h04, 0);
    chk(rd, 3);
    repeat (50) @(posedge clk);
    chk(auth_level, 2);
    press(4, 2, 0);
    repeat (3) @(posedge clk);
    chk({auth_level, rf_mute, power_applied}, {2'h1, 1'b1, 8'hF9});
    repeat (40) @(posedge clk);
    chk(rf_mute, 0);
    apb(0, 8'h00, 0);
    chk(rd, 32'h0000_0081);
    $display("test time-out and reset done");
    press(4, 1, 0);
    press(0, 1, 0);
    press(4, 1, 16'h4444);
    press(4, 1, 16'h1111);
    repeat (40) @(posedge clk);
    chk({auth_level, input_blocked}, {2'h0, 1'b0});
    press(4, 0, 16'h1111);
    chk(input_blocked, 1);
    press(4, 0, 16'h4444);
    repeat (40) @(posedge clk);
    chk(auth_level, 0);
    press(4, 0, 16'h4444);
    chk(auth_level, 1);
    $display("test lock done");
    end_sim();
  end
endmodule
